// ---- cise_pkg.sv ----
// Purpose: Constants and types for the core interrupt status/enable block
// Assumes: APB with 32-bit data, one word per register
// Notes:   Register byte offsets are chosen locally
package cise_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_PERIPH_FLAGS   = 8'h04;
    localparam logic [7:0] ADDR_PERIPH_ENABLE  = 8'h08;
    localparam logic [7:0] ADDR_EDGE_SELECT    = 8'h0c;
    localparam logic [7:0] ADDR_GLOBAL_CTRL    = 8'h10;
    localparam logic [7:0] ADDR_EVT_STATUS     = 8'h14;
    localparam logic [7:0] ADDR_EVT_MASK       = 8'h18;

    // ==========================================================
    // Field positions in the status/control register
    localparam int BIT_PERIPH_PENDING = 7;
    localparam int BIT_COUNTER_FLAG   = 6;
    localparam int BIT_TIMER_FLAG     = 5;
    localparam int BIT_EXT_FLAG       = 4;
    localparam int BIT_PERIPH_GEN     = 3;
    localparam int BIT_COUNTER_EN     = 2;
    localparam int BIT_TIMER_EN       = 1;
    localparam int BIT_EXT_EN         = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPH         = 8'h00;
    localparam logic [1:0] RST_EDGE_SELECT    = 2'h0;
    localparam logic       RST_GLOBAL_DIS     = 1'b1;
    localparam logic [3:0] RST_EVT            = 4'h0;

    // Vector addresses handed to the core
    localparam logic [7:0] VEC_EXT_PIN   = 8'h08;
    localparam logic [7:0] VEC_TIMER     = 8'h10;
    localparam logic [7:0] VEC_COUNTER   = 8'h18;
    localparam logic [7:0] VEC_PERIPHRAL = 8'h20;

    // Interrupt source 2-bit code, listed highest priority first (external pin first)
    typedef enum logic [1:0] {
        CISE_SRC_EXT     = 2'b00,
        CISE_SRC_TIMER   = 2'b01,
        CISE_SRC_COUNTER = 2'b11,
        CISE_SRC_PERIPH  = 2'b10
    } cise_src_t;

    typedef struct packed {
        logic       req;
        cise_src_t  src;
        logic [7:0] vector;
    } cise_irq_req_t;

endpackage

// ---- cise_edge_det.sv ----
// Purpose: Synchronise a pin and detect the selected edge
// Assumes: Pin asynchronous to ref_clk
// Notes:   Two flops before any logic reads the pin
`timescale 1ns/1ps
module cise_edge_det (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Pin and select
    input  wire logic pin_in,
    input  wire logic rising_sel,
    // Result
    output logic      edge_pulse
);

    logic       sync1_reg;
    logic       sync2_reg;
    logic       prev_reg;
    // Holds edges off until prev_reg carries a real pin sample, so no false edge after reset
    logic [2:0] arm_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            arm_reg   <= 3'h0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            arm_reg   <= {arm_reg[1:0], 1'b1};
        end
    end

    // Select 1 = rising, 0 = falling
    assign edge_pulse = arm_reg[2] & (rising_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg));

endmodule

// ---- cise_core_irq.sv ----
// Purpose: Core interrupt status/enable register with vectoring handshake
// Assumes: Core pulses vector_ack one cycle when it takes the offered vector
// Notes:   Peripheral flags are inputs; their enables live here
// Functional notes
// - Set external pin flag on the selected edge of the external pin.
// - Clear external pin flag when the core vectors to its vector.
// - Global peripheral enable gates all peripheral interrupts.
// - Counter pin edge enable allows or suppresses its interrupt.
// - Timer-zero overflow enable allows or suppresses its interrupt.
// - External pin edge enable allows or suppresses its interrupt.
// - Peripheral pending is OR of peripheral flags ANDed with enables.
// - Clear timer-zero flag when the core vectors to its vector.
// - Global disable set at reset and on every interrupt response.
`timescale 1ns/1ps
module cise_core_irq #(
    parameter int PERIPH_W = 8
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Event sources
    input  wire logic                external_irq_pin,
    input  wire logic                counter_clock_pin,
    input  wire logic                timer_zero_overflow,
    input  wire logic [PERIPH_W-1:0] periph_flags,
    // Core vectoring
    output cise_pkg::cise_irq_req_t  core_req,
    input  wire logic                vector_ack,
    input  wire logic                return_from_irq,
    // Interrupt line
    output logic                     irq
);

    // ==========================================================
    // Registers
    logic [7:0]          stat_reg;
    logic [PERIPH_W-1:0] pen_reg;
    logic [1:0]          esel_reg;
    logic                gdis_reg;
    logic [3:0]          evt_reg;
    logic [3:0]          emask_reg;
    logic [7:0]          stat_next;
    logic [3:0]          evt_next;
    logic                gdis_next;

    // ==========================================================
    // Bus decode
    wire wr_en      = psel & penable & pwrite;
    wire rd_en      = psel & penable & ~pwrite;
    wire hit_stat   = (paddr == cise_pkg::ADDR_STATUS_CONTROL);
    wire hit_pflag  = (paddr == cise_pkg::ADDR_PERIPH_FLAGS);
    wire hit_pen    = (paddr == cise_pkg::ADDR_PERIPH_ENABLE);
    wire hit_esel   = (paddr == cise_pkg::ADDR_EDGE_SELECT);
    wire hit_gctl   = (paddr == cise_pkg::ADDR_GLOBAL_CTRL);
    wire hit_evt    = (paddr == cise_pkg::ADDR_EVT_STATUS);
    wire hit_emask  = (paddr == cise_pkg::ADDR_EVT_MASK);
    wire hit_any    = hit_stat | hit_pflag | hit_pen | hit_esel | hit_gctl | hit_evt | hit_emask;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // ==========================================================
    // Edge detection
    logic ext_edge;
    logic cnt_edge;

    cise_edge_det u_ext_edge (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .pin_in     (external_irq_pin),
        .rising_sel (esel_reg[0]),
        .edge_pulse (ext_edge)
    );

    cise_edge_det u_cnt_edge (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .pin_in     (counter_clock_pin),
        .rising_sel (esel_reg[1]),
        .edge_pulse (cnt_edge)
    );

    // ==========================================================
    // Pending and request selection
    wire periph_pending = |(periph_flags & pen_reg);
    wire ext_act   = stat_reg[cise_pkg::BIT_EXT_FLAG] & stat_reg[cise_pkg::BIT_EXT_EN];
    wire tmr_act   = stat_reg[cise_pkg::BIT_TIMER_FLAG] & stat_reg[cise_pkg::BIT_TIMER_EN];
    wire cnt_act   = stat_reg[cise_pkg::BIT_COUNTER_FLAG] & stat_reg[cise_pkg::BIT_COUNTER_EN];
    wire per_act   = periph_pending & stat_reg[cise_pkg::BIT_PERIPH_GEN];
    wire any_act   = ext_act | tmr_act | cnt_act | per_act;
    wire req_live  = any_act & ~gdis_reg;

    cise_pkg::cise_src_t sel_src;
    assign sel_src = ext_act ? cise_pkg::CISE_SRC_EXT :
                     tmr_act ? cise_pkg::CISE_SRC_TIMER :
                     cnt_act ? cise_pkg::CISE_SRC_COUNTER : cise_pkg::CISE_SRC_PERIPH;

    wire [7:0] sel_vec = (sel_src == cise_pkg::CISE_SRC_EXT)     ? cise_pkg::VEC_EXT_PIN :
                         (sel_src == cise_pkg::CISE_SRC_TIMER)   ? cise_pkg::VEC_TIMER :
                         (sel_src == cise_pkg::CISE_SRC_COUNTER) ? cise_pkg::VEC_COUNTER :
                                                                   cise_pkg::VEC_PERIPHRAL;

    assign core_req.req    = req_live;
    assign core_req.src    = sel_src;
    assign core_req.vector = sel_vec;

    // Taken only while the request is live, so a stray ack does nothing
    wire taken     = vector_ack & req_live;
    wire take_ext  = taken & (sel_src == cise_pkg::CISE_SRC_EXT);
    wire take_tmr  = taken & (sel_src == cise_pkg::CISE_SRC_TIMER);
    wire take_cnt  = taken & (sel_src == cise_pkg::CISE_SRC_COUNTER);

    // ==========================================================
    // Next state for status/control
    wire stat_wr = wr_en & hit_stat;
    always_comb begin
        stat_next = stat_reg;
        if (stat_wr) begin
            stat_next[6:0] = pwdata[6:0];
        end
        // Hardware clear on vectoring, then edge set wins over any clear
        if (take_ext) begin
            stat_next[cise_pkg::BIT_EXT_FLAG] = 1'b0;
        end
        if (take_tmr) begin
            stat_next[cise_pkg::BIT_TIMER_FLAG] = 1'b0;
        end
        if (take_cnt) begin
            stat_next[cise_pkg::BIT_COUNTER_FLAG] = 1'b0;
        end
        if (ext_edge) begin
            stat_next[cise_pkg::BIT_EXT_FLAG] = 1'b1;
        end
        if (timer_zero_overflow) begin
            stat_next[cise_pkg::BIT_TIMER_FLAG] = 1'b1;
        end
        if (cnt_edge) begin
            stat_next[cise_pkg::BIT_COUNTER_FLAG] = 1'b1;
        end
        stat_next[cise_pkg::BIT_PERIPH_PENDING] = periph_pending;
    end

    // Global disable: response sets it, return or software may clear it
    always_comb begin
        gdis_next = gdis_reg;
        if (wr_en & hit_gctl) begin
            gdis_next = pwdata[0];
        end
        if (return_from_irq) begin
            gdis_next = 1'b0;
        end
        if (taken) begin
            gdis_next = 1'b1;
        end
    end

    // Sticky event bits: set wins over write-one-to-clear
    wire [3:0] evt_set = {timer_zero_overflow, cnt_edge, ext_edge, taken};
    always_comb begin
        evt_next = evt_reg;
        if (wr_en & hit_evt) begin
            evt_next = evt_reg & ~pwdata[3:0];
        end
        evt_next = evt_next | evt_set;
    end

    // ==========================================================
    // Register update
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_reg  <= cise_pkg::RST_STATUS_CONTROL;
            pen_reg   <= PERIPH_W'(cise_pkg::RST_PERIPH);
            esel_reg  <= cise_pkg::RST_EDGE_SELECT;
            gdis_reg  <= cise_pkg::RST_GLOBAL_DIS;
            evt_reg   <= cise_pkg::RST_EVT;
            emask_reg <= cise_pkg::RST_EVT;
        end else begin
            stat_reg  <= stat_next;
            gdis_reg  <= gdis_next;
            evt_reg   <= evt_next;
            if (wr_en & hit_pen) begin
                pen_reg <= pwdata[PERIPH_W-1:0];
            end
            if (wr_en & hit_esel) begin
                esel_reg <= pwdata[1:0];
            end
            if (wr_en & hit_emask) begin
                emask_reg <= pwdata[3:0];
            end
        end
    end

    // ==========================================================
    // Read data from flops
    logic [31:0] rd_mux;
    assign rd_mux = hit_stat  ? {24'h000000, stat_reg} :
                    hit_pflag ? {{(32-PERIPH_W){1'b0}}, periph_flags} :
                    hit_pen   ? {{(32-PERIPH_W){1'b0}}, pen_reg} :
                    hit_esel  ? {30'h00000000, esel_reg} :
                    hit_gctl  ? {31'h00000000, gdis_reg} :
                    hit_evt   ? {28'h0000000, evt_reg} :
                    hit_emask ? {28'h0000000, emask_reg} : 32'h00000000;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_next & emask_reg);
        end
    end

    // ==========================================================
    // Checks
    sequence s_ext_taken;
        take_ext && !ext_edge;
    endsequence

    a_ext_flag_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ext_edge |=> stat_reg[cise_pkg::BIT_EXT_FLAG])
        else $error("external flag not set after edge");

    a_ext_flag_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_ext_taken |=> !stat_reg[cise_pkg::BIT_EXT_FLAG])
        else $error("external flag not cleared on vectoring");

    a_periph_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !stat_reg[cise_pkg::BIT_PERIPH_GEN] |-> !per_act)
        else $error("peripheral interrupt passed with global enable low");

    a_counter_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_req.req && core_req.src == cise_pkg::CISE_SRC_COUNTER) |-> stat_reg[cise_pkg::BIT_COUNTER_EN])
        else $error("counter request while disabled");

    a_timer_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_req.req && core_req.src == cise_pkg::CISE_SRC_TIMER) |-> stat_reg[cise_pkg::BIT_TIMER_EN])
        else $error("timer request while disabled");

    a_ext_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (core_req.req && core_req.src == cise_pkg::CISE_SRC_EXT) |-> stat_reg[cise_pkg::BIT_EXT_EN])
        else $error("external request while disabled");

    a_pending_or: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 stat_reg[cise_pkg::BIT_PERIPH_PENDING] == $past(|(periph_flags & pen_reg)))
        else $error("pending bit not OR of enabled flags");

    a_timer_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (take_tmr && !timer_zero_overflow) |=> !stat_reg[cise_pkg::BIT_TIMER_FLAG])
        else $error("timer flag not cleared on vectoring");

    a_disable_on_take: assert property (@(posedge ref_clk) disable iff (sys_rst)
        taken |=> gdis_reg && !core_req.req)
        else $error("global disable not set on response");

    a_req_needs_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
        core_req.req |-> !gdis_reg && any_act)
        else $error("request without enabled flag or with disable");

    // Offer and answer steps of a vectoring to the external pin vector
    sequence s_ext_offer;
        core_req.req && core_req.vector == cise_pkg::VEC_EXT_PIN;
    endsequence

    sequence s_core_ack;
        vector_ack;
    endsequence

    a_ext_take_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_ext_offer ##0 s_core_ack |=> gdis_reg && !core_req.req)
        else $error("external vectoring did not set global disable");

    a_ext_allow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ext_act && !gdis_reg) |->
            core_req.req && core_req.vector == cise_pkg::VEC_EXT_PIN)
        else $error("enabled external flag not offered");

    a_timer_allow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (tmr_act && !ext_act && !gdis_reg) |->
            core_req.req && core_req.vector == cise_pkg::VEC_TIMER)
        else $error("enabled timer flag not offered");

    a_counter_allow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cnt_act && !ext_act && !tmr_act && !gdis_reg) |->
            core_req.req && core_req.vector == cise_pkg::VEC_COUNTER)
        else $error("enabled counter flag not offered");

    a_periph_allow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (periph_pending && stat_reg[cise_pkg::BIT_PERIPH_GEN] && !gdis_reg) |-> core_req.req)
        else $error("enabled peripheral interrupt not offered");

    a_timer_flag_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        timer_zero_overflow |=> stat_reg[cise_pkg::BIT_TIMER_FLAG])
        else $error("timer flag not set after overflow");

    a_counter_flag_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cnt_edge |=> stat_reg[cise_pkg::BIT_COUNTER_FLAG])
        else $error("counter flag not set after edge");

    a_disable_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        gdis_reg |-> !core_req.req)
        else $error("request while global disable set");

endmodule

// ---- cise_core_model.sv ----
// Purpose: Behavioural core sequencer that answers vector requests
// Assumes: Ack is a one-cycle pulse; its delay is set by the bench
// Notes:   Return pulse follows the bench request one cycle later
`timescale 1ns/1ps
module cise_core_model (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // Block side
    input  wire cise_pkg::cise_irq_req_t core_req,
    output logic                         vector_ack,
    output logic                         return_from_irq,
    // Bench control
    input  wire logic [3:0]              ack_delay,
    input  wire logic                    ret_req,
    output logic [7:0]                   last_vec
);
    logic [3:0] wait_cnt;

    // ==========================================================
    // Sequencer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vector_ack      <= 1'b0;
            return_from_irq <= 1'b0;
            wait_cnt        <= 4'h0;
            last_vec        <= 8'h00;
        end else begin
            vector_ack      <= 1'b0;
            return_from_irq <= ret_req;
            wait_cnt        <= 4'h0;
            // Slow answers keep the request pending for a while
            if (core_req.req && !vector_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt == ack_delay) begin
                    vector_ack <= 1'b1;
                    last_vec   <= core_req.vector;
                end
            end
        end
    end
endmodule

// ---- cise_core_irq_tb.sv ----
// Purpose: Self-checking bench for the core interrupt status/enable block
// Assumes: APB answers in the first access cycle, checked by waiting
// Notes:   Scenarios build on each other's register state
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module cise_core_irq_tb;
    logic                    ref_clk, sys_rst, psel, penable, pwrite, pslverr, pready;
    logic [7:0]              paddr, periph_flags, last_vec;
    logic [31:0]             pwdata, prdata, q;
    logic                    ext_pin, cnt_pin, tmr_ovf, vector_ack, ret_irq, ret_req, irq, err;
    logic [3:0]              ack_delay;
    cise_pkg::cise_irq_req_t core_req;
    int                      error_cnt, cmp_count;

    cise_core_irq cise_core_irq_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_irq_pin(ext_pin), .counter_clock_pin(cnt_pin),
        .timer_zero_overflow(tmr_ovf), .periph_flags(periph_flags), .core_req(core_req),
        .vector_ack(vector_ack), .return_from_irq(ret_irq), .irq(irq));
    cise_core_model cise_core_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .core_req(core_req),
        .vector_ack(vector_ack), .return_from_irq(ret_irq), .ack_delay(ack_delay),
        .ret_req(ret_req), .last_vec(last_vec));

    // ==========================================================
    // Clock, reset and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end

    // ==========================================================
    // APB master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h0);
        rd_chk(cise_pkg::ADDR_GLOBAL_CTRL, 32'h1);
        rd_chk(8'h40, 32'h0);
        `CHK(err, 1'b1)
        `CHK(pready, 1'b1)
        `CHK(core_req.req, 1'b0)
    endtask
    task automatic t_ext();
        wr(cise_pkg::ADDR_GLOBAL_CTRL, 32'h0);
        ext_pin <= 1'b0;
        wait_clk(6);
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h10);
        `CHK(core_req.req, 1'b0)
        ack_delay <= 4'h5;
        wr(cise_pkg::ADDR_STATUS_CONTROL, 32'h11);
        wait_clk(1);
        `CHK(core_req.req, 1'b1)
        `CHK(core_req.src, cise_pkg::CISE_SRC_EXT)
        `CHK(core_req.vector, cise_pkg::VEC_EXT_PIN)
        wait_clk(9);
        `CHK(last_vec, cise_pkg::VEC_EXT_PIN)
        `CHK(core_req.req, 1'b0)
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h01);
        rd_chk(cise_pkg::ADDR_GLOBAL_CTRL, 32'h1);
        ext_pin <= 1'b1;
    endtask
    task automatic t_timer();
        ret_req <= 1'b1;
        @(posedge ref_clk);
        ret_req <= 1'b0;
        wait_clk(2);
        rd_chk(cise_pkg::ADDR_GLOBAL_CTRL, 32'h0);
        wr(cise_pkg::ADDR_STATUS_CONTROL, 32'h0);
        ack_delay <= 4'h0;
        tmr_ovf <= 1'b1;
        @(posedge ref_clk);
        tmr_ovf <= 1'b0;
        wait_clk(3);
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h20);
        `CHK(core_req.req, 1'b0)
        wr(cise_pkg::ADDR_STATUS_CONTROL, 32'h22);
        wait_clk(4);
        `CHK(last_vec, cise_pkg::VEC_TIMER)
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h02);
    endtask
    task automatic t_counter();
        wr(cise_pkg::ADDR_EDGE_SELECT, 32'h2);
        wr(cise_pkg::ADDR_STATUS_CONTROL, 32'h04);
        wr(cise_pkg::ADDR_GLOBAL_CTRL, 32'h0);
        cnt_pin <= 1'b1;
        wait_clk(8);
        `CHK(last_vec, cise_pkg::VEC_COUNTER)
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h04);
    endtask
    task automatic t_periph();
        periph_flags <= 8'h05;
        wr(cise_pkg::ADDR_PERIPH_ENABLE, 32'h04);
        wr(cise_pkg::ADDR_STATUS_CONTROL, 32'h0);
        wr(cise_pkg::ADDR_GLOBAL_CTRL, 32'h0);
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h80);
        `CHK(core_req.req, 1'b0)
        rd_chk(cise_pkg::ADDR_PERIPH_FLAGS, 32'h05);
        wr(cise_pkg::ADDR_PERIPH_ENABLE, 32'h02);
        rd_chk(cise_pkg::ADDR_STATUS_CONTROL, 32'h0);
        wr(cise_pkg::ADDR_PERIPH_ENABLE, 32'h04);
        wr(cise_pkg::ADDR_STATUS_CONTROL, 32'h08);
        wait_clk(4);
        `CHK(last_vec, cise_pkg::VEC_PERIPHRAL)
        `CHK(core_req.req, 1'b0)
        periph_flags <= 8'h00;
    endtask
    task automatic t_irq();
        // Every event kind has fired by now, all masked
        rd_chk(cise_pkg::ADDR_EVT_STATUS, 32'hf);
        `CHK(irq, 1'b0)
        wr(cise_pkg::ADDR_EVT_MASK, 32'h1);
        wait_clk(2);
        `CHK(irq, 1'b1)
        wr(cise_pkg::ADDR_EVT_STATUS, 32'h1);
        wait_clk(2);
        `CHK(irq, 1'b0)
        rd_chk(cise_pkg::ADDR_EVT_STATUS, 32'he);
        wr(cise_pkg::ADDR_EVT_STATUS, 32'he);
        rd_chk(cise_pkg::ADDR_EVT_STATUS, 32'h0);
    endtask

    // ==========================================================
    // Verdict
    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        error_cnt = 0; cmp_count = 0;
        sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; ext_pin = 1'b1; cnt_pin = 1'b0; tmr_ovf = 1'b0;
        periph_flags = 8'h00; ack_delay = 4'h0; ret_req = 1'b0;
        wait_clk(5);
        sys_rst <= 1'b0;
        t_reset();
        t_ext();
        t_timer();
        t_counter();
        t_periph();
        t_irq();
        finish_test();
    end
endmodule
